// ==== rtl/pdepc_top.sv ====
// Port D / port E pin control with an Avalon-MM register slave.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module pdepc_top (
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_rst_n,
	// Avalon-MM slave.
	input  wire logic [4:0]                  i_avs_address,
	input  wire logic                        i_avs_read,
	input  wire logic                        i_avs_write,
	input  wire logic [31:0]                 i_avs_writedata,
	output logic      [31:0]                 o_avs_readdata,
	output logic                             o_avs_waitrequest,
	// Port D pins.
	input  wire logic [7:0]                  i_port_d_pins,
	output pdepc_pkg::pdepc_pin8_type        o_port_d,
	// Port E pins 0..2 and the input-only pin 3.
	input  wire logic [2:0]                  i_port_e_pins,
	input  wire logic                        i_port_e_pin3,
	output pdepc_pkg::pdepc_pin3_type        o_port_e,
	output logic                             o_master_clear_active,
	input  wire logic                        i_master_clear_enable_cfg,
	// Slave-port strobes from the external processor, already on this clock.
	input  wire pdepc_pkg::pdepc_psp_ev_type i_psp_ev,
	output logic      [7:0]                  o_psp_write_data,
	// PWM engine outputs for channels B, C, D and its shutdown state.
	input  wire logic [2:0]                  i_pwm_chan_out,
	input  wire logic                        i_pwm_shutdown,
	input  wire logic                        i_pwm_tristate_on_shutdown
);
	// Register storage.
	logic [7:0] port_d_latch_q;    // Output latch of port D.
	logic [7:0] port_d_dir_q;      // Direction of port D, 1 is input.
	logic [2:0] port_e_latch_q;    // Output latch of port E pins 0..2.
	logic [2:0] port_e_dir_q;      // Direction of port E pins 0..2.
	logic       slave_mode_q;      // Slave-port mode bit.
	logic       ibf_q;             // Input buffer full.
	logic       obf_q;             // Output buffer full.
	logic       input_buffer_overflow_q;            // Input buffer overflow.
	logic [7:0] capture_pwm_q;     // Capture/PWM control register.
	logic [2:0] analog_cfg_q;      // 1 marks a port E pin as analog.
	logic [7:0] psp_data_q;        // Data latched from the external processor.
	logic [31:0] rdata_q;          // Registered read data.
	logic        ack_q;            // One-cycle answer strobe.

	// Three-flop synchronisers for the pin inputs.
	logic [7:0] d_s1_q, d_s2_q, d_s3_q, d_stable_q;
	logic [3:0] e_s1_q, e_s2_q, e_s3_q, e_stable_q;

	// Decoded access strobes; one pulse per bus transfer.
	logic wr_en;
	logic rd_en;
	logic psp_active;
	logic pwm_multi;
	assign wr_en = i_avs_write & ~ack_q;
	assign rd_en = i_avs_read  & ~ack_q;

	// The slave port is off while PWM runs dual or quad output.
	// Either mode bit set means dual or quad output, so both bits are watched.
	assign pwm_multi  = capture_pwm_q[pdepc_pkg::PWM_BIT_M1] |
	                    capture_pwm_q[pdepc_pkg::PWM_BIT_M0];
	assign psp_active = slave_mode_q & ~pwm_multi;

	// Waitrequest drops for the cycle after the request is seen, so every access takes one wait.
	assign o_avs_waitrequest = ~ack_q;
	assign o_avs_readdata    = rdata_q;

	// Answer strobe: high for one cycle after each request.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
		end
	end

	// Pin synchronisers; a change counts only when stages two and three agree.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			d_s1_q     <= 8'h00;
			d_s2_q     <= 8'h00;
			d_s3_q     <= 8'h00;
			d_stable_q <= 8'h00;
			e_s1_q     <= 4'h0;
			e_s2_q     <= 4'h0;
			e_s3_q     <= 4'h0;
			e_stable_q <= 4'h0;
		end else begin
			d_s1_q <= i_port_d_pins;
			d_s2_q <= d_s1_q;
			d_s3_q <= d_s2_q;
			e_s1_q <= {i_port_e_pin3, i_port_e_pins};
			e_s2_q <= e_s1_q;
			e_s3_q <= e_s2_q;
			for (int b = 0; b < 8; b++) begin
				if (d_s2_q[b] == d_s3_q[b]) begin
					d_stable_q[b] <= d_s3_q[b];
				end
			end
			for (int b = 0; b < 4; b++) begin
				if (e_s2_q[b] == e_s3_q[b]) begin
					e_stable_q[b] <= e_s3_q[b];
				end
			end
		end
	end

	// Port D latch: written through either the pin or the latch address.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_d_latch_q <= pdepc_pkg::RST_PORT_D_LATCH;
		end else if (wr_en && (i_avs_address == pdepc_pkg::ADDR_PORT_D_PINS ||
		                      i_avs_address == pdepc_pkg::ADDR_PORT_D_LATCH)) begin
			port_d_latch_q <= i_avs_writedata[7:0];
		end
	end

	// Port D direction; PWM-shared pins therefore come up as inputs.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_d_dir_q <= pdepc_pkg::RST_PORT_D_DIR;
		end else if (wr_en && i_avs_address == pdepc_pkg::ADDR_PORT_D_DIR) begin
			port_d_dir_q <= i_avs_writedata[7:0];
		end
	end

	// Port E latch, direction and mode bit.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port_e_latch_q <= pdepc_pkg::RST_PORT_E_LATCH;
			port_e_dir_q   <= pdepc_pkg::RST_PORT_E_DIR[2:0];
			slave_mode_q   <= pdepc_pkg::RST_PORT_E_DIR[pdepc_pkg::E_BIT_MODE];
		end else if (wr_en) begin
			if (i_avs_address == pdepc_pkg::ADDR_PORT_E_PINS ||
			    i_avs_address == pdepc_pkg::ADDR_PORT_E_LATCH) begin
				port_e_latch_q <= i_avs_writedata[2:0];
			end
			if (i_avs_address == pdepc_pkg::ADDR_PORT_E_DIR) begin
				port_e_dir_q <= i_avs_writedata[2:0];
				slave_mode_q <= i_avs_writedata[pdepc_pkg::E_BIT_MODE];
			end
		end
	end

	// Capture/PWM control and analog selection, plain software registers.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			capture_pwm_q <= pdepc_pkg::RST_CAPTURE_PWM;
			analog_cfg_q  <= pdepc_pkg::RST_ANALOG_CFG;
		end else if (wr_en) begin
			if (i_avs_address == pdepc_pkg::ADDR_CAPTURE_PWM) begin
				capture_pwm_q <= i_avs_writedata[7:0];
			end
			if (i_avs_address == pdepc_pkg::ADDR_ANALOG_CFG) begin
				analog_cfg_q <= i_avs_writedata[2:0];
			end
		end
	end

	// Slave-port status flags; a hardware set beats a software clear in the same cycle.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ibf_q      <= 1'b0;
			obf_q      <= 1'b0;
			input_buffer_overflow_q     <= 1'b0;
			psp_data_q <= 8'h00;
		end else begin
			// Software reading the port D pins empties the input buffer.
			if (rd_en && i_avs_address == pdepc_pkg::ADDR_PORT_D_PINS) begin
				ibf_q <= 1'b0;
			end
			// Software writing the latch fills the output buffer.
			if (wr_en && (i_avs_address == pdepc_pkg::ADDR_PORT_D_PINS ||
			              i_avs_address == pdepc_pkg::ADDR_PORT_D_LATCH)) begin
				obf_q <= 1'b1;
			end
			// Overflow is cleared by writing zero to its bit.
			if (wr_en && i_avs_address == pdepc_pkg::ADDR_PORT_E_DIR &&
			    !i_avs_writedata[pdepc_pkg::E_BIT_OVF]) begin
				input_buffer_overflow_q <= 1'b0;
			end
			if (psp_active && i_psp_ev.rd_strobe) begin
				obf_q <= 1'b0;
			end
			if (psp_active && i_psp_ev.wr_strobe) begin
				psp_data_q <= d_stable_q;
				ibf_q      <= 1'b1;
				if (ibf_q) begin
					input_buffer_overflow_q <= 1'b1;
				end
			end
		end
	end

	// Pin drive: latch under direction, then slave port, then PWM on pins 5..7.
	// The PWM branch is chosen at elaboration, so no channel index ever falls below zero.
	// Pins 0..4 carry no PWM channel, so their drive stops at the slave-port override.
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_port_d
			if (g >= 5) begin : g_pwm_pin
				// Shared pin: PWM beats latch and slave data while it runs multi-output.
				always_comb begin
					o_port_d.out[g] = port_d_latch_q[g];
					o_port_d.oe[g]  = ~port_d_dir_q[g];
					if (psp_active) begin
						o_port_d.oe[g] = i_psp_ev.rd_strobe;
					end
					if (pwm_multi) begin
						o_port_d.out[g] = i_pwm_chan_out[g-5];
						// A shutdown may release the pin rather than force a level.
						o_port_d.oe[g]  = ~(i_pwm_shutdown & i_pwm_tristate_on_shutdown);
					end
				end
			end else begin : g_plain_pin
				// Plain pin: latch under direction, overridden by the slave port.
				always_comb begin
					o_port_d.out[g] = port_d_latch_q[g];
					o_port_d.oe[g]  = ~port_d_dir_q[g];
					if (psp_active) begin
						o_port_d.oe[g] = i_psp_ev.rd_strobe;
					end
				end
			end
		end
	endgenerate

	// Port E drivers follow direction even when analog.
	assign o_port_e.out = port_e_latch_q;
	assign o_port_e.oe  = ~port_e_dir_q;
	assign o_master_clear_active = i_master_clear_enable_cfg;
	assign o_psp_write_data      = psp_data_q;

	// Read mux, registered on the answer cycle.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= pdepc_pkg::RD_UNMAPPED;
		end else if (rd_en) begin
			unique case (i_avs_address)
				pdepc_pkg::ADDR_PORT_D_PINS: begin
					rdata_q <= {24'h00_0000, d_stable_q};
				end
				pdepc_pkg::ADDR_PORT_D_LATCH: begin
					rdata_q <= {24'h00_0000, port_d_latch_q};
				end
				pdepc_pkg::ADDR_PORT_D_DIR: begin
					rdata_q <= {24'h00_0000, port_d_dir_q};
				end
				pdepc_pkg::ADDR_PORT_E_PINS: begin
					// Pin 3 shows only when it is a plain input; analog pins read zero.
					rdata_q <= {28'h000_0000,
					            e_stable_q[3] & ~i_master_clear_enable_cfg,
					            e_stable_q[2:0] & ~analog_cfg_q};
				end
				pdepc_pkg::ADDR_PORT_E_LATCH: begin
					rdata_q <= {29'h0000_0000, port_e_latch_q};
				end
				pdepc_pkg::ADDR_PORT_E_DIR: begin
					rdata_q <= {24'h00_0000, ibf_q, obf_q, input_buffer_overflow_q, slave_mode_q,
					            1'b0, port_e_dir_q};
				end
				pdepc_pkg::ADDR_CAPTURE_PWM: begin
					rdata_q <= {24'h00_0000, capture_pwm_q};
				end
				pdepc_pkg::ADDR_ANALOG_CFG: begin
					rdata_q <= {29'h0000_0000, analog_cfg_q};
				end
				default: begin
					rdata_q <= pdepc_pkg::RD_UNMAPPED;
				end
			endcase
		end
	end

	// Checks.
	chk_dir_tristate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!psp_active && !pwm_multi) |-> (o_port_d.oe == ~port_d_dir_q))
		else $error("port D drive does not follow direction");
	chk_pwm_priority: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(pwm_multi && !i_pwm_shutdown) |-> (o_port_d.out[7:5] == i_pwm_chan_out && &o_port_d.oe[7:5]))
		else $error("PWM does not own pins 5 to 7");
	chk_pwm_shutdown: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(pwm_multi && i_pwm_shutdown && i_pwm_tristate_on_shutdown) |-> (o_port_d.oe[7:5] == 3'h0))
		else $error("PWM pins not released in shutdown");
	chk_latch_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_en && i_avs_address == pdepc_pkg::ADDR_PORT_D_PINS) |=> (port_d_latch_q == $past(i_avs_writedata[7:0])))
		else $error("pin write did not reach latch");
	chk_bit3_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(rd_en && i_avs_address == pdepc_pkg::ADDR_PORT_E_DIR) |=> (rdata_q[3] == 1'b0 && !o_avs_waitrequest))
		else $error("port E direction bit 3 not zero");
	chk_psp_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pwm_multi |-> !psp_active)
		else $error("slave port live during multi-output PWM");
	sequence s_ext_write;
		psp_active && i_psp_ev.wr_strobe;
	endsequence
	chk_psp_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_ext_write |=> (ibf_q && o_psp_write_data == $past(d_stable_q)))
		else $error("external write not captured");
	chk_analog_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(rd_en && i_avs_address == pdepc_pkg::ADDR_PORT_E_PINS) |=> ((rdata_q[2:0] & $past(analog_cfg_q)) == 3'h0))
		else $error("analog pin read not zero");
	chk_psp_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(psp_active && !pwm_multi) |-> (o_port_d.out == port_d_latch_q))
		else $error("slave port does not drive latch");

	// The slave port drives every pin exactly while the external read strobe stands.
	chk_psp_read_oe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(psp_active && !pwm_multi) |-> (o_port_d.oe == {8{i_psp_ev.rd_strobe}}))
		else $error("slave port drive does not follow read strobe");

	// Port E drivers obey direction even when the pin is selected as analog.
	chk_e_dir_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |-> (o_port_e.oe == ~port_e_dir_q))
		else $error("port E drive does not follow direction");

	// Every access is answered after exactly one wait state.
	// A master that waits longer only costs time, but a missing answer would hang the core.
	chk_one_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
		else $error("bus access not answered after one wait");
endmodule : pdepc_top

// ==== shared/pdepc_pkg.sv ====
// Package for the port D / port E pin control block: register map, fields, resets, carriers.
package pdepc_pkg;
	// Register byte addresses on the Avalon-MM word bus (word aligned).
	localparam logic [4:0] ADDR_PORT_D_PINS   = 5'h00;
	localparam logic [4:0] ADDR_PORT_D_LATCH  = 5'h04;
	localparam logic [4:0] ADDR_PORT_D_DIR    = 5'h08;
	localparam logic [4:0] ADDR_PORT_E_PINS   = 5'h0C;
	localparam logic [4:0] ADDR_PORT_E_LATCH  = 5'h10;
	localparam logic [4:0] ADDR_PORT_E_DIR    = 5'h14;
	localparam logic [4:0] ADDR_CAPTURE_PWM   = 5'h18;
	localparam logic [4:0] ADDR_ANALOG_CFG    = 5'h1C;
	// Field positions inside the port E direction / slave status register.
	localparam int E_BIT_MODE = 4;
	localparam int E_BIT_OVF  = 5;
	localparam int E_BIT_OBF  = 6;
	localparam int E_BIT_IBF  = 7;
	// Field positions inside the capture/PWM control register.
	localparam int PWM_BIT_M0 = 6;
	localparam int PWM_BIT_M1 = 7;
	// Reset values.
	localparam logic [7:0] RST_PORT_D_LATCH = 8'h00;
	localparam logic [7:0] RST_PORT_D_DIR   = 8'hFF;
	localparam logic [7:0] RST_PORT_E_DIR   = 8'h07;
	localparam logic [2:0] RST_PORT_E_LATCH = 3'h0;
	localparam logic [7:0] RST_CAPTURE_PWM  = 8'h00;
	localparam logic [2:0] RST_ANALOG_CFG   = 3'h7;
	// Value read back from an unmapped address.
	localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;
	// Port D pins carried as one group: level out, drive enable.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pdepc_pin8_type;
	// Port E pins 0..2 carried as one group.
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
	} pdepc_pin3_type;
	// Slave-port event strobes from the slave-port handshake logic.
	typedef struct packed {
		logic wr_strobe;
		logic rd_strobe;
	} pdepc_psp_ev_type;
endpackage : pdepc_pkg

// ==== verif/pdepc_ext_proc.sv ====
// External processor model on the parallel slave port, with port D wire resolution.
`timescale 1ns/10ps
module pdepc_ext_proc (
	input  wire logic                 i_clk_sys,
	input  wire pdepc_pkg::pdepc_pin8_type i_port_d,
	output logic [7:0]                o_port_d_pins,
	output pdepc_pkg::pdepc_psp_ev_type o_psp_ev
);
	logic [7:0] ext_val_q; // Last value put on the bus.
	logic       ext_en_q;  // High while this side drives the bus.
	initial begin
		ext_val_q = 8'h00;
		ext_en_q  = 1'b0;
		o_psp_ev  = '0;
	end
	// A released bus has no pull, so it shows the inverse of the last value.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			o_port_d_pins[i] = i_port_d.oe[i] ? i_port_d.out[i] :
				(ext_en_q ? ext_val_q[i] : ~ext_val_q[i]);
		end
	end
	task automatic drive(input logic [7:0] v);
		@(posedge i_clk_sys);
		ext_val_q <= v;
		ext_en_q  <= 1'b1;
	endtask : drive
	task automatic release_bus();
		@(posedge i_clk_sys);
		ext_en_q <= 1'b0;
	endtask : release_bus
	// Data is held well around the strobe since the pins pass a synchroniser.
	task automatic write_byte(input logic [7:0] v);
		drive(v);
		repeat (5) @(posedge i_clk_sys);
		o_psp_ev.wr_strobe <= 1'b1;
		@(posedge i_clk_sys);
		o_psp_ev.wr_strobe <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		ext_en_q <= 1'b0;
	endtask : write_byte
	task automatic read_enable(input logic on);
		@(posedge i_clk_sys);
		o_psp_ev.rd_strobe <= on;
	endtask : read_enable
endmodule : pdepc_ext_proc

// ==== verif/tb_top.sv ====
// Self-checking testbench for the port D / port E pin control block.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0, wr = 1'b0;
	logic [31:0] wdat = 32'h0000_0000, rdat;
	logic wait_req, mc_act, e3 = 1'b1, mce = 1'b0;
	logic [7:0] d_pins, psp_wdat, v;
	logic [2:0] e_pins, e_ext = 3'h7, pwm = 3'h0;
	logic sd = 1'b0, sd_tri = 1'b0;
	pdepc_pkg::pdepc_pin8_type pd;
	pdepc_pkg::pdepc_pin3_type pe;
	pdepc_pkg::pdepc_psp_ev_type ev;
	int errors = 0, checked = 0;
	// The clock toggles every 2.5 ns, half of its 5 ns period.
	always #2.5 clk = ~clk;
	// Port E wire: the block wins where it drives, the bench elsewhere.
	assign e_pins = (pe.oe & pe.out) | (~pe.oe & e_ext);
	pdepc_top u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wait_req), .i_port_d_pins(d_pins),
		.o_port_d(pd), .i_port_e_pins(e_pins), .i_port_e_pin3(e3), .o_port_e(pe),
		.o_master_clear_active(mc_act), .i_master_clear_enable_cfg(mce), .i_psp_ev(ev),
		.o_psp_write_data(psp_wdat), .i_pwm_chan_out(pwm), .i_pwm_shutdown(sd),
		.i_pwm_tristate_on_shutdown(sd_tri));
	pdepc_ext_proc u_ext (.i_clk_sys(clk), .i_port_d(pd), .o_port_d_pins(d_pins),
		.o_psp_ev(ev));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One bus transfer; waitrequest and read data are both taken at the rising edge.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wdat <= {24'h0000_00, d};
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		if (n >= 50) chk("waitrequest", 8'h00, 8'h01);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr_reg
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] q;
		repeat (6) @(posedge clk);
		bus(1'b0, a, 8'h00, q);
		chk(nm, exp & m, q & m);
	endtask : rd_chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	// Watchdog well beyond the couple of hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and analog masking of port E.
		rd_chk("d_dir", pdepc_pkg::ADDR_PORT_D_DIR, 8'hFF, 8'hFF);
		rd_chk("e_dir", pdepc_pkg::ADDR_PORT_E_DIR, 8'h0F, 8'h07);
		rd_chk("analog", pdepc_pkg::ADDR_ANALOG_CFG, 8'h07, 8'h07);
		rd_chk("e_pins", pdepc_pkg::ADDR_PORT_E_PINS, 8'h0F, 8'h08);
		chk("d_oe", 8'h00, pd.oe);
		$display("test reset done");
		// Latch against pins, bit order, drive and tristate.
		wr_reg(pdepc_pkg::ADDR_PORT_D_PINS, 8'hA5);
		wr_reg(pdepc_pkg::ADDR_PORT_D_DIR, 8'h00);
		chk("d_oe", 8'hFF, pd.oe);
		chk("d_out", 8'hA5, pd.out);
		rd_chk("d_pins", pdepc_pkg::ADDR_PORT_D_PINS, 8'hFF, 8'hA5);
		wr_reg(pdepc_pkg::ADDR_PORT_D_DIR, 8'hFF);
		u_ext.drive(8'h3C);
		rd_chk("d_pins", pdepc_pkg::ADDR_PORT_D_PINS, 8'hFF, 8'h3C);
		rd_chk("d_latch", pdepc_pkg::ADDR_PORT_D_LATCH, 8'hFF, 8'hA5);
		u_ext.release_bus();
		$display("test port_d done");
		// Slave port: read drive ignores direction, write data captured.
		wr_reg(pdepc_pkg::ADDR_PORT_E_DIR, 8'h17);
		u_ext.read_enable(1'b1);
		@(negedge clk);
		chk("psp_oe", 8'hFF, pd.oe);
		chk("psp_out", 8'hA5, pd.out);
		u_ext.read_enable(1'b0);
		u_ext.write_byte(8'h5A);
		chk("psp_wdat", 8'h5A, psp_wdat);
		rd_chk("e_status", pdepc_pkg::ADDR_PORT_E_DIR, 8'h98, 8'h90);
		$display("test slave_port done");
		// PWM takes pins 5..7 and turns the slave port off.
		wr_reg(pdepc_pkg::ADDR_PORT_D_DIR, 8'h10);
		wr_reg(pdepc_pkg::ADDR_CAPTURE_PWM, 8'h40);
		u_ext.read_enable(1'b1);
		pwm <= 3'h5;
		@(negedge clk);
		chk("pwm_out", 8'hA0, pd.out & 8'hE0);
		chk("pwm_oe", 8'hEF, pd.oe);
		@(posedge clk);
		sd <= 1'b1;
		sd_tri <= 1'b1;
		@(negedge clk);
		chk("pwm_sd_oe", 8'h0F, pd.oe);
		u_ext.read_enable(1'b0);
		sd <= 1'b0;
		$display("test pwm done");
		// Port E digital output, analog masking, master clear pin.
		wr_reg(pdepc_pkg::ADDR_ANALOG_CFG, 8'h00);
		wr_reg(pdepc_pkg::ADDR_PORT_E_DIR, 8'h00);
		wr_reg(pdepc_pkg::ADDR_PORT_E_LATCH, 8'h05);
		chk("e_out", 8'h75, {1'b0, pe.oe, 1'b0, pe.out});
		rd_chk("e_pins", pdepc_pkg::ADDR_PORT_E_PINS, 8'h0F, 8'h0D);
		e3 <= 1'b0;
		rd_chk("e_pin3", pdepc_pkg::ADDR_PORT_E_PINS, 8'h0F, 8'h05);
		wr_reg(pdepc_pkg::ADDR_ANALOG_CFG, 8'h07);
		chk("e_oe", 8'h07, {5'h00, pe.oe});
		mce <= 1'b1;
		rd_chk("e_pins", pdepc_pkg::ADDR_PORT_E_PINS, 8'h0F, 8'h00);
		chk("master_clear_input", 8'h01, {7'h00, mc_act});
		$display("test port_e done");
		give_verdict();
	end
endmodule : tb_top
